// ### hw/bad_pkg.sv
// Constants, address map and types of the board address decoder
// Function
// - Take 41-bit physical address; split whole space into fixed regions.
// - 1FE.0000.0000 to 1FF.FFFF.FFFF is noncacheable processor subsystem and PCI space.
// - Main memory in 256 MByte banks 0, 2, 4, 5, 6, 7 at fixed bases.
// - CSR space: bus module, then memory management unit, then interrupt engine.
// - Memory control unit up to 1FE.00FF.FFFF, split by an interrupt engine slot at 1FE.00FF.F020 to 1FE.00FF.F027.
// - PCI configuration at 1FE.0100.0100, PCI I/O from 1FE.0200.0000.
// - Bridge window 1FF.F000.0000 to 1FF.F17F.FFFF inside PCI memory space.
// - Bridge window is fixed and answers from reset, with no configuration.
// - Chip select 0: boot flash and user flash, or PROM and reserved.
// - Chip select 1 for real-time clock and nonvolatile RAM window.
// - Chip select 2 always mirrors the PROM, whatever the boot selection.
// - Chip select 4 for four 8-byte serial channel windows.
// - Chip select 7 for the 256-byte system configuration window.
// - Bridge's own configuration window selects no expansion chip select.
// - Unassigned bridge addresses belong to the expansion bus; nobody else claims them.
// - System configuration registers are byte wide, one byte address each.
// - Boot-select bit can only be set; reset alone clears it.
package bad_pkg;

    localparam int ADDR_W = 41;
    localparam int CS_W = 8;
    localparam int BYTE_OFF_W = 8;
    localparam int BANK_COUNT = 6;
    localparam int SER_CH_COUNT = 4;

    // Chip select numbers on the expansion bus
    localparam int CS_BOOT = 0;
    localparam int CS_RTC = 1;
    localparam int CS_PROM_MIRROR = 2;
    localparam int CS_SERIAL = 4;
    localparam int CS_SYSCONF = 7;

    // Top level split
    localparam logic [40:0] MEM_LO = 41'h000_0000_0000;
    localparam logic [40:0] MEM_HI = 41'h001_FFFF_FFFF;
    localparam logic [40:0] CACHEABLE_HI = 41'h007_FFFF_FFFF;
    localparam logic [40:0] DNU_LO = 41'h1FC_0000_0000;
    localparam logic [40:0] DNU_HI = 41'h1FD_FFFF_FFFF;
    localparam logic [40:0] SUBSYS_LO = 41'h1FE_0000_0000;
    localparam logic [40:0] SUBSYS_HI = 41'h1FF_FFFF_FFFF;

    // Memory banks, all 256 MByte
    localparam logic [40:0] BANK_LAST = 41'h000_0FFF_FFFF;
    localparam logic [40:0] BANK_BASE [BANK_COUNT] = '{
        41'h000_0000_0000, 41'h000_8000_0000, 41'h001_0000_0000,
        41'h001_1000_0000, 41'h001_8000_0000, 41'h001_9000_0000};
    localparam logic [2:0] BANK_ID [BANK_COUNT] = '{
        3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};

    // Internal configuration space
    localparam logic [40:0] BUS_A_LO = 41'h1FE_0000_0000;
    localparam logic [40:0] BUS_A_HI = 41'h1FE_0000_01FF;
    localparam logic [40:0] MMU_A_LO = 41'h1FE_0000_0200;
    localparam logic [40:0] MMU_A_HI = 41'h1FE_0000_03FF;
    localparam logic [40:0] IRQ_A_LO = 41'h1FE_0000_0400;
    localparam logic [40:0] IRQ_A_HI = 41'h1FE_0000_1FFF;
    localparam logic [40:0] BUS_B_LO = 41'h1FE_0000_2000;
    localparam logic [40:0] BUS_B_HI = 41'h1FE_0000_5FFF;
    localparam logic [40:0] IRQ_B_LO = 41'h1FE_0000_6000;
    localparam logic [40:0] IRQ_B_HI = 41'h1FE_0000_9FFF;
    localparam logic [40:0] MMU_B_LO = 41'h1FE_0000_A000;
    localparam logic [40:0] MMU_B_HI = 41'h1FE_0000_A7FF;
    localparam logic [40:0] IRQ_C_LO = 41'h1FE_0000_A800;
    localparam logic [40:0] IRQ_C_HI = 41'h1FE_0000_EFFF;
    localparam logic [40:0] MCU_A_LO = 41'h1FE_0000_F000;
    localparam logic [40:0] MCU_A_HI = 41'h1FE_00FF_F01F;
    localparam logic [40:0] IRQ_D_LO = 41'h1FE_00FF_F020;
    localparam logic [40:0] IRQ_D_HI = 41'h1FE_00FF_F027;
    localparam logic [40:0] MCU_B_LO = 41'h1FE_00FF_F028;
    localparam logic [40:0] MCU_B_HI = 41'h1FE_00FF_FFFF;
    localparam logic [40:0] BUS_C_LO = 41'h1FE_0100_0000;
    localparam logic [40:0] BUS_C_HI = 41'h1FE_0100_0041;

    // PCI spaces
    localparam logic [40:0] PCI_CFG_LO = 41'h1FE_0100_0100;
    localparam logic [40:0] PCI_CFG_HI = 41'h1FE_01FF_FFFF;
    localparam logic [40:0] PCI_IO_LO = 41'h1FE_0200_0000;
    localparam logic [40:0] PCI_IO_HI = 41'h1FE_02FF_FFFF;
    localparam logic [40:0] PCI_MEM_LO = 41'h1FF_0000_0000;
    localparam logic [40:0] PCI_MEM_HI = 41'h1FF_FFFF_FFFF;

    // Boot I/O bridge window and its expansion bus devices
    localparam logic [40:0] BRG_LO = 41'h1FF_F000_0000;
    localparam logic [40:0] BRG_HI = 41'h1FF_F17F_FFFF;
    localparam logic [40:0] CS0_LO = 41'h1FF_F000_0000;
    localparam logic [40:0] CS0_BOOT_HI = 41'h1FF_F00F_FFFF;
    localparam logic [40:0] CS0_HI = 41'h1FF_F0FF_FFFF;
    localparam logic [40:0] CS1_LO = 41'h1FF_F100_6000;
    localparam logic [40:0] CS1_HI = 41'h1FF_F100_7FFF;
    localparam logic [40:0] CS2_LO = 41'h1FF_F110_0000;
    localparam logic [40:0] CS2_HI = 41'h1FF_F11F_FFFF;
    localparam logic [40:0] SER_BASE = 41'h1FF_F130_0000;
    localparam logic [40:0] SER_CH_STEP = 41'h000_0000_0100;
    localparam logic [40:0] SER_CH_LAST = 41'h000_0000_0007;
    localparam logic [40:0] CS7_LO = 41'h1FF_F160_0100;
    localparam logic [40:0] CS7_HI = 41'h1FF_F160_01FF;
    localparam logic [40:0] BRG_CFG_LO = 41'h1FF_F170_0000;
    localparam logic [40:0] BRG_CFG_HI = 41'h1FF_F17F_FFFF;

    // Access size code of a single byte
    localparam logic [1:0] SIZE_BYTE = 2'h0;

    typedef enum logic [3:0] {
        BAD_TGT_NONE = 4'b0000,
        BAD_TGT_MEM = 4'b0001,
        BAD_TGT_BUS = 4'b0010,
        BAD_TGT_MMU = 4'b0011,
        BAD_TGT_IRQ = 4'b0100,
        BAD_TGT_MCU = 4'b0101,
        BAD_TGT_PCI_CFG = 4'b0110,
        BAD_TGT_PCI_IO = 4'b0111,
        BAD_TGT_PCI_MEM = 4'b1000,
        BAD_TGT_EXP_CS = 4'b1001,
        BAD_TGT_BRG_CFG = 4'b1010,
        BAD_TGT_EXP_RSVD = 4'b1011,
        BAD_TGT_RESERVED = 4'b1100
    } bad_target_t;

    typedef enum logic [2:0] {
        BAD_BOOT_NONE = 3'b000,
        BAD_BOOT_FLASH_BOOT = 3'b001,
        BAD_BOOT_USER_FLASH = 3'b010,
        BAD_BOOT_PROM = 3'b011
    } bad_boot_t;

    typedef struct packed {
        logic resp_valid;
        logic resp_err;
        logic resp_write;
        bad_target_t target;
        logic [7:0] cs;
        logic [2:0] bank;
        logic bank_hit;
        bad_boot_t boot;
        logic [1:0] ser_ch;
        logic [7:0] reg_byte;
        logic cacheable;
    } bad_state_t;

    typedef struct packed {
        logic flag;
    } bad_sticky_t;

endpackage : bad_pkg

// ### hw/bad_sticky_bit.sv
// Set-only control bit that only reset clears
`timescale 1ns/1ps
module bad_sticky_bit (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic set_req,
    output logic bit_q
);
    bad_pkg::bad_sticky_t state_q;
    bad_pkg::bad_sticky_t state_d;

    // Writing zero has no path here, so a stray clear cannot drop boot mode
    always_comb begin
        state_d = state_q;
        state_d.flag = state_q.flag | set_req;
    end

    // Reset is the only way back to zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign bit_q = state_q.flag;

endmodule : bad_sticky_bit

// ### hw/bad_decoder.sv
// Physical address decoder: region, bank and expansion chip select per request
`timescale 1ns/1ps
module bad_decoder (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [40:0] req_addr,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic boot_select_switch,
    input wire logic flash_boot_set,
    output logic resp_valid,
    output logic resp_err,
    output logic resp_write,
    output logic [3:0] resp_target,
    output logic [7:0] chip_sel,
    output logic [2:0] bank_sel,
    output logic bank_hit,
    output logic [2:0] boot_region,
    output logic [1:0] serial_chan,
    output logic [7:0] sysconf_byte,
    output logic resp_cacheable,
    output logic flash_boot_select_bit
);

    // Inclusive range test, shared by every region compare except the cacheable limit
    function automatic logic in_range(
        input logic [40:0] addr,
        input logic [40:0] lo,
        input logic [40:0] hi
    );
        in_range = (addr >= lo) && (addr <= hi);
    endfunction : in_range

    bad_pkg::bad_state_t state_q;
    bad_pkg::bad_state_t state_d;

    logic flash_mode;
    logic [bad_pkg::BANK_COUNT-1:0] bank_vec;
    logic [bad_pkg::SER_CH_COUNT-1:0] ser_vec;

    // Top level region hits
    logic hit_mem_space;
    logic hit_cache_rsvd;
    logic hit_dnu;
    logic hit_subsys;

    // Internal configuration space hits
    logic hit_bus;
    logic hit_mmu;
    logic hit_irq;
    logic hit_mcu;

    // PCI and bridge hits
    logic hit_pci_cfg;
    logic hit_pci_io;
    logic hit_pci_mem;
    logic hit_brg;
    logic hit_cs0;
    logic hit_cs0_boot;
    logic hit_cs1;
    logic hit_cs2;
    logic hit_cs7;
    logic hit_brg_cfg;

    // Boot-select control bit, set by software writing a one
    bad_sticky_bit u_boot_bit (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_req(flash_boot_set),
        .bit_q(flash_boot_select_bit)
    );

    // Switch ON or bit set routes chip select 0 to flash; a set in the
    // same cycle as a request takes effect from the next request
    assign flash_mode = boot_select_switch | flash_boot_select_bit;

    // One comparator per populated memory bank
    generate
        for (genvar g = 0; g < bad_pkg::BANK_COUNT; g++) begin : g_bank
            assign bank_vec[g] = in_range(req_addr, bad_pkg::BANK_BASE[g],
                bad_pkg::BANK_BASE[g] + bad_pkg::BANK_LAST);
        end
    endgenerate

    // Serial channels A to D, one 8-byte window each, step 0100 above the base
    generate
        for (genvar g = 0; g < bad_pkg::SER_CH_COUNT; g++) begin : g_ser
            localparam logic [40:0] CH_LO =
                bad_pkg::SER_BASE + bad_pkg::SER_CH_STEP * 41'(g + 1);
            assign ser_vec[g] = in_range(req_addr, CH_LO,
                CH_LO + bad_pkg::SER_CH_LAST);
        end
    endgenerate

    // Coarse split of the 41-bit space
    assign hit_mem_space = in_range(req_addr, bad_pkg::MEM_LO, bad_pkg::MEM_HI);
    assign hit_cache_rsvd = (req_addr <= bad_pkg::CACHEABLE_HI);
    assign hit_dnu = in_range(req_addr, bad_pkg::DNU_LO, bad_pkg::DNU_HI);
    assign hit_subsys = in_range(req_addr, bad_pkg::SUBSYS_LO, bad_pkg::SUBSYS_HI);

    // Bus module has three pieces, interrupt engine four, the others two
    assign hit_bus = in_range(req_addr, bad_pkg::BUS_A_LO, bad_pkg::BUS_A_HI)
        | in_range(req_addr, bad_pkg::BUS_B_LO, bad_pkg::BUS_B_HI)
        | in_range(req_addr, bad_pkg::BUS_C_LO, bad_pkg::BUS_C_HI);
    assign hit_mmu = in_range(req_addr, bad_pkg::MMU_A_LO, bad_pkg::MMU_A_HI)
        | in_range(req_addr, bad_pkg::MMU_B_LO, bad_pkg::MMU_B_HI);
    assign hit_irq = in_range(req_addr, bad_pkg::IRQ_A_LO, bad_pkg::IRQ_A_HI)
        | in_range(req_addr, bad_pkg::IRQ_B_LO, bad_pkg::IRQ_B_HI)
        | in_range(req_addr, bad_pkg::IRQ_C_LO, bad_pkg::IRQ_C_HI)
        | in_range(req_addr, bad_pkg::IRQ_D_LO, bad_pkg::IRQ_D_HI);
    assign hit_mcu = in_range(req_addr, bad_pkg::MCU_A_LO, bad_pkg::MCU_A_HI)
        | in_range(req_addr, bad_pkg::MCU_B_LO, bad_pkg::MCU_B_HI);

    // PCI configuration, I/O and memory windows
    assign hit_pci_cfg = in_range(req_addr, bad_pkg::PCI_CFG_LO, bad_pkg::PCI_CFG_HI);
    assign hit_pci_io = in_range(req_addr, bad_pkg::PCI_IO_LO, bad_pkg::PCI_IO_HI);
    assign hit_pci_mem = in_range(req_addr, bad_pkg::PCI_MEM_LO, bad_pkg::PCI_MEM_HI);

    // Bridge window compares are constants only, so they work straight
    // out of reset before any PCI enumeration has run
    assign hit_brg = in_range(req_addr, bad_pkg::BRG_LO, bad_pkg::BRG_HI);
    assign hit_cs0 = in_range(req_addr, bad_pkg::CS0_LO, bad_pkg::CS0_HI);
    assign hit_cs0_boot = in_range(req_addr, bad_pkg::CS0_LO, bad_pkg::CS0_BOOT_HI);
    assign hit_cs1 = in_range(req_addr, bad_pkg::CS1_LO, bad_pkg::CS1_HI);
    assign hit_cs2 = in_range(req_addr, bad_pkg::CS2_LO, bad_pkg::CS2_HI);
    assign hit_cs7 = in_range(req_addr, bad_pkg::CS7_LO, bad_pkg::CS7_HI);
    assign hit_brg_cfg = in_range(req_addr, bad_pkg::BRG_CFG_LO, bad_pkg::BRG_CFG_HI);

    // Priority decode; all fields idle between requests so no chip select
    // lingers past the one answer cycle
    always_comb begin
        state_d = '0;
        state_d.target = bad_pkg::BAD_TGT_NONE;
        state_d.boot = bad_pkg::BAD_BOOT_NONE;
        state_d.resp_valid = req_valid;
        state_d.resp_write = req_valid & req_write;
        if (req_valid) begin
            state_d.cacheable = hit_cache_rsvd;
            if (hit_mem_space) begin
                // Holes between banks answer as reserved
                state_d.target = bad_pkg::BAD_TGT_RESERVED;
                state_d.resp_err = 1'b1;
                for (int i = 0; i < bad_pkg::BANK_COUNT; i++) begin
                    if (bank_vec[i]) begin
                        state_d.target = bad_pkg::BAD_TGT_MEM;
                        state_d.resp_err = 1'b0;
                        state_d.bank_hit = 1'b1;
                        state_d.bank = bad_pkg::BANK_ID[i];
                    end
                end
            end else if (hit_dnu) begin
                // Never expected; still answered so the core cannot hang
                state_d.target = bad_pkg::BAD_TGT_RESERVED;
                state_d.resp_err = 1'b1;
            end else if (!hit_subsys) begin
                state_d.target = bad_pkg::BAD_TGT_RESERVED;
                state_d.resp_err = 1'b1;
            end else if (hit_bus) begin
                state_d.target = bad_pkg::BAD_TGT_BUS;
            end else if (hit_mmu) begin
                state_d.target = bad_pkg::BAD_TGT_MMU;
            end else if (hit_irq) begin
                state_d.target = bad_pkg::BAD_TGT_IRQ;
            end else if (hit_mcu) begin
                state_d.target = bad_pkg::BAD_TGT_MCU;
            end else if (hit_pci_cfg) begin
                state_d.target = bad_pkg::BAD_TGT_PCI_CFG;
            end else if (hit_pci_io) begin
                state_d.target = bad_pkg::BAD_TGT_PCI_IO;
            end else if (hit_brg) begin
                // Bridge claims its whole window ahead of PCI memory
                state_d.target = bad_pkg::BAD_TGT_EXP_RSVD;
                state_d.resp_err = 1'b1;
                if (hit_brg_cfg) begin
                    state_d.target = bad_pkg::BAD_TGT_BRG_CFG;
                    state_d.resp_err = 1'b0;
                end else if (hit_cs0) begin
                    if (flash_mode) begin
                        state_d.target = bad_pkg::BAD_TGT_EXP_CS;
                        state_d.resp_err = 1'b0;
                        state_d.cs[bad_pkg::CS_BOOT] = 1'b1;
                        state_d.boot = hit_cs0_boot ? bad_pkg::BAD_BOOT_FLASH_BOOT
                            : bad_pkg::BAD_BOOT_USER_FLASH;
                    end else if (hit_cs0_boot) begin
                        state_d.target = bad_pkg::BAD_TGT_EXP_CS;
                        state_d.resp_err = 1'b0;
                        state_d.cs[bad_pkg::CS_BOOT] = 1'b1;
                        state_d.boot = bad_pkg::BAD_BOOT_PROM;
                    end
                end else if (hit_cs1) begin
                    state_d.target = bad_pkg::BAD_TGT_EXP_CS;
                    state_d.resp_err = 1'b0;
                    state_d.cs[bad_pkg::CS_RTC] = 1'b1;
                end else if (hit_cs2) begin
                    // Mirror ignores switch and control bit on purpose, so
                    // the PROM stays reachable after a switch to flash
                    state_d.target = bad_pkg::BAD_TGT_EXP_CS;
                    state_d.resp_err = 1'b0;
                    state_d.cs[bad_pkg::CS_PROM_MIRROR] = 1'b1;
                    state_d.boot = bad_pkg::BAD_BOOT_PROM;
                end else if (|ser_vec) begin
                    state_d.target = bad_pkg::BAD_TGT_EXP_CS;
                    state_d.resp_err = 1'b0;
                    state_d.cs[bad_pkg::CS_SERIAL] = 1'b1;
                    for (int i = 0; i < bad_pkg::SER_CH_COUNT; i++) begin
                        if (ser_vec[i]) begin
                            state_d.ser_ch = 2'(i);
                        end
                    end
                end else if (hit_cs7) begin
                    // Registers are one byte each; wider access is refused
                    if (req_size == bad_pkg::SIZE_BYTE) begin
                        state_d.target = bad_pkg::BAD_TGT_EXP_CS;
                        state_d.resp_err = 1'b0;
                        state_d.cs[bad_pkg::CS_SYSCONF] = 1'b1;
                        state_d.reg_byte = req_addr[bad_pkg::BYTE_OFF_W-1:0];
                    end
                end
            end else if (hit_pci_mem) begin
                state_d.target = bad_pkg::BAD_TGT_PCI_MEM;
            end else begin
                // Gaps in internal space and the PCI reserved stretch
                state_d.target = bad_pkg::BAD_TGT_RESERVED;
                state_d.resp_err = 1'b1;
            end
        end
    end

    // One register stage: every answer comes one edge after its request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign resp_valid = state_q.resp_valid;
    assign resp_err = state_q.resp_err;
    assign resp_write = state_q.resp_write;
    assign resp_target = state_q.target;
    assign chip_sel = state_q.cs;
    assign bank_sel = state_q.bank;
    assign bank_hit = state_q.bank_hit;
    assign boot_region = state_q.boot;
    assign serial_chan = state_q.ser_ch;
    assign sysconf_byte = state_q.reg_byte;
    assign resp_cacheable = state_q.cacheable;

endmodule : bad_decoder

// ### tb/bad_core_model.sv
// Processor core model that issues physical address requests
`timescale 1ns/1ps
module bad_core_model (
    input wire logic ref_clk,
    output logic req_valid,
    output logic [40:0] req_addr,
    output logic req_write,
    output logic [1:0] req_size
);
    // Idle from time zero
    initial begin
        req_valid = 1'b0;
        req_addr = 41'h0;
        req_write = 1'b0;
        req_size = 2'h0;
    end
    // One request per call, none for 1FC.0000.0000 to 1FD.FFFF.FFFF; after release the address is inverted so stale values never match
    task automatic issue(input logic [40:0] a, input logic wr, input logic [1:0] sz);
        if (a >= 41'h1FC_0000_0000 && a <= 41'h1FD_FFFF_FFFF) begin
            return;
        end
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_addr = a;
        req_write = wr;
        req_size = sz;
        @(negedge ref_clk);
        req_valid = 1'b0;
        req_addr = ~a;
        req_size = ~sz;
    endtask : issue
endmodule : bad_core_model

// ### tb/bad_decoder_props.sv
// Concurrent checks on the address decoder ports
`timescale 1ns/1ps
module bad_decoder_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [40:0] req_addr,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic flash_boot_set,
    input wire logic resp_valid,
    input wire logic resp_err,
    input wire logic resp_write,
    input wire logic [3:0] resp_target,
    input wire logic [7:0] chip_sel,
    input wire logic [2:0] bank_sel,
    input wire logic bank_hit,
    input wire logic [2:0] boot_region,
    input wire logic [7:0] sysconf_byte,
    input wire logic resp_cacheable,
    input wire logic flash_boot_select_bit
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Window hits, qualified by a request
    wire [7:0] addr_lo = req_addr[7:0];
    wire in_rtc = req_valid && req_addr >= 41'h1FF_F100_6000 && req_addr <= 41'h1FF_F100_7FFF;
    wire in_mir = req_valid && req_addr >= 41'h1FF_F110_0000 && req_addr <= 41'h1FF_F11F_FFFF;
    wire in_cfg = req_valid && req_addr >= 41'h1FF_F160_0100 && req_addr <= 41'h1FF_F160_01FF;
    wire in_bcfg = req_valid && req_addr >= 41'h1FF_F170_0000 && req_addr <= 41'h1FF_F17F_FFFF;
    a_answer_next: assert property (req_valid |=> resp_valid && resp_write == $past(req_write))
        else $error("no answer one cycle after request");
    a_idle_quiet: assert property (!req_valid |=> !resp_valid && chip_sel == 8'h00)
        else $error("response without request");
    a_rtc_select: assert property (in_rtc |=> chip_sel == 8'h02 && resp_target == 4'h9)
        else $error("clock window not on select 1");
    a_prom_mirror: assert property (in_mir |=> chip_sel == 8'h04 && boot_region == 3'h3)
        else $error("mirror window wrong");
    a_sysconf_byte: assert property (in_cfg && req_size == 2'h0 |=>
        chip_sel == 8'h80 && sysconf_byte == $past(addr_lo)) else $error("config window wrong");
    a_brg_cfg_quiet: assert property (in_bcfg |=> chip_sel == 8'h00 && resp_target == 4'hA)
        else $error("bridge config window drove a select");
    a_boot_sticky: assert property (flash_boot_select_bit |=> flash_boot_select_bit)
        else $error("boot bit cleared without reset");
    a_boot_set: assert property (flash_boot_set |=> flash_boot_select_bit)
        else $error("boot bit not set");
    a_subsys_uncached: assert property (req_valid && req_addr[40:33] == 8'hFF |=> !resp_cacheable)
        else $error("subsystem space cacheable");
    a_bank_six: assert property (req_valid && req_addr[40:28] == 13'h018 |=>
        bank_hit && bank_sel == 3'h6 && !resp_err) else $error("bank 6 not hit");
    // Main scenarios reached
    c_rtc: cover property (in_rtc);
    c_boot_set: cover property (flash_boot_set ##1 flash_boot_select_bit);
    c_err: cover property (resp_valid && resp_err);
endmodule : bad_decoder_props
bind bad_decoder bad_decoder_props chk_u (.ref_clk, .rst, .req_valid, .req_addr, .req_write,
    .req_size, .flash_boot_set, .resp_valid, .resp_err, .resp_write, .resp_target, .chip_sel,
    .bank_sel, .bank_hit, .boot_region, .sysconf_byte, .resp_cacheable, .flash_boot_select_bit);

// ### tb/bad_decoder_tb_top.sv
// Self-checking bench for the address decoder
`timescale 1ns/1ps
module bad_decoder_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic boot_select_switch = 1'b0;
    logic flash_boot_set = 1'b0;
    logic bit_exp = 1'b0;
    logic req_valid, req_write, resp_valid, resp_err, resp_write, bank_hit, resp_cacheable, fbit;
    logic [40:0] req_addr;
    logic [1:0] req_size, serial_chan;
    logic [3:0] resp_target;
    logic [7:0] chip_sel, sysconf_byte;
    logic [2:0] bank_sel, boot_region;
    int errors = 0;
    int comparisons = 0;
    int seed = 92310;
    always #5 ref_clk = ~ref_clk;
    bad_core_model core_u (.ref_clk, .req_valid, .req_addr, .req_write, .req_size);
    bad_decoder dut_u (.ref_clk, .rst, .req_valid, .req_addr, .req_write, .req_size,
        .boot_select_switch, .flash_boot_set, .resp_valid, .resp_err, .resp_write, .resp_target,
        .chip_sel, .bank_sel, .bank_hit, .boot_region, .serial_chan, .sysconf_byte,
        .resp_cacheable, .flash_boot_select_bit(fbit));
    // Expected {target, chip_sel, err, boot_region}; CSR pieces only as far as probed
    function automatic logic [15:0] exp_f(logic [40:0] a, logic [1:0] sz, logic bt);
        if (a <= 41'h001_FFFF_FFFF && a[40:28] inside {0, 8, 16, 17, 24, 25}) return 16'h1000;
        if (a < 41'h1FE_0000_0000) return 16'hC008;
        if (a <= 41'h1FE_0000_01FF) return 16'h2000;
        if (a <= 41'h1FE_0000_03FF) return 16'h3000;
        if (a <= 41'h1FE_0000_1FFF) return 16'h4000;
        if (a >= 41'h1FE_0000_F000 && a <= 41'h1FE_00FF_F01F) return 16'h5000;
        if (a >= 41'h1FE_00FF_F020 && a <= 41'h1FE_00FF_F027) return 16'h4000;
        if (a >= 41'h1FE_0100_0100 && a <= 41'h1FE_01FF_FFFF) return 16'h6000;
        if (a >= 41'h1FE_0200_0000 && a <= 41'h1FE_02FF_FFFF) return 16'h7000;
        if (a < 41'h1FF_0000_0000) return 16'hC008;
        if (a < 41'h1FF_F000_0000 || a > 41'h1FF_F17F_FFFF) return 16'h8000;
        if (a <= 41'h1FF_F00F_FFFF) return bt ? 16'h9011 : 16'h9013;
        if (a <= 41'h1FF_F0FF_FFFF) return bt ? 16'h9012 : 16'hB008;
        if (a >= 41'h1FF_F100_6000 && a <= 41'h1FF_F100_7FFF) return 16'h9020;
        if (a >= 41'h1FF_F110_0000 && a <= 41'h1FF_F11F_FFFF) return 16'h9043;
        if (a[40:12] == 29'h1FFF1300 && a[11:8] inside {[1:4]} && a[7:3] == 0) return 16'h9100;
        if (a >= 41'h1FF_F160_0100 && a <= 41'h1FF_F160_01FF) return sz ? 16'hB008 : 16'h9800;
        if (a >= 41'h1FF_F170_0000) return 16'hA000;
        return 16'hB008;
    endfunction : exp_f
    task automatic chk(input string nm, input logic [40:0] e, input logic [40:0] g);
        comparisons++;
        if (e !== g) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One request, then every response field against the map
    task automatic probe(input logic [40:0] a, input logic [1:0] sz);
        logic [15:0] e;
        logic wr;
        e = exp_f(a, sz, boot_select_switch | bit_exp);
        wr = 1'($random(seed));
        core_u.issue(a, wr, sz);
        chk("resp_valid", 1, resp_valid);
        chk("resp_write", wr, resp_write);
        chk("resp_target", e[15:12], resp_target);
        chk("chip_sel", e[11:4], chip_sel);
        chk("resp_err", e[3], resp_err);
        chk("boot_region", e[2:0], boot_region);
        chk("resp_cacheable", a <= 41'h007_FFFF_FFFF, resp_cacheable);
        chk("bank_sel", (e[15:12] == 4'h1) ? {1'b1, a[32], a[31], a[28]} : 4'h0,
            {bank_hit, bank_sel});
        if (e[11:4] == 8'h10) chk("serial_chan", 2'(a[9:8] - 2'h1), serial_chan);
        if (e[11:4] == 8'h80) chk("sysconf_byte", a[7:0], sysconf_byte);
    endtask : probe
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    logic [40:0] corners [] = '{41'h000_0FFF_FFFF, 41'h000_1000_0000, 41'h001_9FFF_FFFF,
        41'h001_A000_0000, 41'h002_0000_0000, 41'h008_0000_0000, 41'h1FE_0000_0000,
        41'h1FE_0000_03FF, 41'h1FE_0000_0400, 41'h1FE_00FF_F018, 41'h1FE_00FF_F020,
        41'h1FE_0100_0100, 41'h1FE_01FF_FFFF, 41'h1FE_0200_0000, 41'h1FE_0300_0000,
        41'h1FF_0000_0000, 41'h1FF_F100_5FFF, 41'h1FF_F100_6000, 41'h1FF_F100_7FFF,
        41'h1FF_F110_0000, 41'h1FF_F130_0100, 41'h1FF_F130_0407, 41'h1FF_F130_0408,
        41'h1FF_F160_01FF, 41'h1FF_F170_0000, 41'h1FF_F17F_FFFF, 41'h1FF_F180_0000,
        41'h001_8000_0000};
    // Watchdog at 20000 cycles, well past the expected run of about 680 cycles
    initial begin
        #200000;
        errors++;
        test_done();
    end
    initial begin
        logic [40:0] a;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        foreach (corners[i]) probe(corners[i], 2'h0);
        $display("test corners done");
        for (int i = 0; i < 300; i++) begin
            boot_select_switch = 1'($random(seed));
            a = 41'({$random(seed), $random(seed)});
            if (i % 3 == 0) a = 41'h1FF_F000_0000 + a % 41'h180_0000;
            if (i % 3 == 1) a = a % 41'h008_0000_0000;
            if (i % 3 == 2) a = 41'h1FF_F160_0100 + a[7:0];
            probe(a, 2'($random(seed)) & {2{i % 3 == 2}});
        end
        $display("test random done");
        boot_select_switch = 1'b0;
        probe(41'h1FF_F010_0000, 2'h0);
        flash_boot_set = 1'b1;
        @(negedge ref_clk);
        flash_boot_set = 1'b0;
        bit_exp = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("boot_bit", 1, fbit);
        probe(41'h1FF_F000_0000, 2'h0);
        probe(41'h1FF_F010_0000, 2'h0);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        bit_exp = 1'b0;
        chk("boot_bit", 0, fbit);
        probe(41'h1FF_F000_0000, 2'h0);
        $display("test boot select done");
        test_done();
    end
endmodule : bad_decoder_tb_top
